// ==== design/vlsr_defines.vh ====
// Constants for the dual nibble variable length shift register.
// Assumes inclusion by bare name from the design files.
`ifndef VLSR_DEFINES_VH
`define VLSR_DEFINES_VH

`define VLSR_NIBBLE_W     4
`define VLSR_CODE_W       4
`define VLSR_TAP_W        5
`define VLSR_TAP_STAGES   17
`define VLSR_MIN_DELAY    5'h03
`define VLSR_MAX_DELAY    5'h12
`define VLSR_FIRST_TAP    5'h02
`define VLSR_LAST_TAP     5'h11
`define VLSR_CODE_RESET   4'h0
`define VLSR_MODE_RESET   1'b0
`define VLSR_DATA_RESET   4'h0

`endif

// ==== design/tap_chain.v ====
// One nibble-wide chain of stage registers with a tap selector feeding
// a final output stage register.
// Assumes the tap select is already registered on the same clock.
`timescale 1ns/1ns
`include "vlsr_defines.vh"

module tap_chain #(
    parameter WIDTH  = `VLSR_NIBBLE_W,
    parameter DEPTH  = `VLSR_TAP_STAGES,
    parameter TAP_W  = `VLSR_TAP_W
) (
    input  wire               clk_sys,
    input  wire               rst,
    input  wire [WIDTH-1:0]   data_in,
    input  wire [TAP_W-1:0]   tap_sel,
    output reg  [WIDTH-1:0]   data_out
);

    // Stage 1 sits in the low bits; no reset, so the line costs no reset
    // routing and holds unknown data until flushed
    reg  [WIDTH*DEPTH-1:0] stage;
    reg  [WIDTH-1:0]       next_data_out;
    integer                i;

    // Stages 1..DEPTH shift every edge, untouched by the tap select
    always @(posedge clk_sys) begin // see RULE3 see RULE11 see RULE12
        stage <= {stage[WIDTH*(DEPTH-1)-1:0], data_in};
    end

    always @* begin // see RULE5
        next_data_out = {WIDTH{1'b0}};
        for (i = 1; i <= DEPTH; i = i + 1) begin
            if (tap_sel == i[TAP_W-1:0]) begin
                next_data_out = stage[(i-1)*WIDTH +: WIDTH];
            end
        end
    end

    // Output stage is reset only so the pins are defined from reset on
    always @(posedge clk_sys or posedge rst) begin // see RULE6
        if (rst) begin
            data_out <= {WIDTH{1'b0}};
        end else begin
            data_out <= next_data_out;
        end
    end

endmodule // tap_chain

// ==== design/variable_length_shift_register.v ====
// Dual 4-bit variable length shift register, 3 to 18 stages of delay.
// Assumes upstream and downstream logic run on clk_sys, so no inputs
// are synchronised.
//
// Contract
// RULE1: Two independent 4-bit chains share one clock, length and mode.
// RULE2: Chain delay programmable over every whole value from 3 to 18.
// RULE3: Each input nibble enters its own stage chain on rising edges.
// RULE4: Low nibble feeds low chain and output; high nibble likewise.
// RULE5: Selector passes any stage two to seventeen into output stage.
// RULE6: Shortest path is stage one, stage two, output stage: three.
// RULE7: Delay equals length code plus three.
// RULE8: Mode low: both nibbles delayed by the length code amount.
// RULE9: Mode high: upper nibble fixed at eighteen, lower follows code.
// RULE10: Length code and mode captured on rising edge, drive selection.
// RULE11: Control changes never disturb stages one to seventeen.
// RULE12: No reset on stages; contents unknown until flushed.
`timescale 1ns/1ns
`include "vlsr_defines.vh"

module variable_length_shift_register #(
    parameter WIDTH  = `VLSR_NIBBLE_W,
    parameter CODE_W = `VLSR_CODE_W,
    parameter TAP_W  = `VLSR_TAP_W,
    parameter DEPTH  = `VLSR_TAP_STAGES
) (
    input  wire              clk_sys,
    input  wire              rst,
    input  wire [WIDTH-1:0]  lower_nibble_in,
    input  wire [WIDTH-1:0]  upper_nibble_in,
    input  wire [CODE_W-1:0] delay_length_code,
    input  wire              fixed_upper_mode,
    output wire [WIDTH-1:0]  lower_nibble_out,
    output wire [WIDTH-1:0]  upper_nibble_out,
    output reg               lower_out_valid,
    output reg               upper_out_valid,
    output reg  [TAP_W-1:0]  lower_delay,
    output reg  [TAP_W-1:0]  upper_delay
);

    // Captured controls
    reg  [CODE_W-1:0] length_code;
    reg               upper_fixed;

    // Tap selections derived from captured controls
    reg  [TAP_W-1:0]  lower_tap;
    reg  [TAP_W-1:0]  upper_tap;

    // Fill tracker: a reset copy of the stage line carrying ones
    reg  [DEPTH-1:0]  filled;
    reg               next_lower_valid;
    reg               next_upper_valid;

    // Code zero selects stage two, so output is three edges behind input
    function [TAP_W-1:0] code_to_tap;
        input [CODE_W-1:0] code;
        begin
            case (code)
                4'h0: begin
                    code_to_tap = 5'h02;
                end
                4'h1: begin
                    code_to_tap = 5'h03;
                end
                4'h2: begin
                    code_to_tap = 5'h04;
                end
                4'h3: begin
                    code_to_tap = 5'h05;
                end
                4'h4: begin
                    code_to_tap = 5'h06;
                end
                4'h5: begin
                    code_to_tap = 5'h07;
                end
                4'h6: begin
                    code_to_tap = 5'h08;
                end
                4'h7: begin
                    code_to_tap = 5'h09;
                end
                4'h8: begin
                    code_to_tap = 5'h0A;
                end
                4'h9: begin
                    code_to_tap = 5'h0B;
                end
                4'hA: begin
                    code_to_tap = 5'h0C;
                end
                4'hB: begin
                    code_to_tap = 5'h0D;
                end
                4'hC: begin
                    code_to_tap = 5'h0E;
                end
                4'hD: begin
                    code_to_tap = 5'h0F;
                end
                4'hE: begin
                    code_to_tap = 5'h10;
                end
                4'hF: begin
                    code_to_tap = 5'h11;
                end
                default: begin
                    code_to_tap = `VLSR_FIRST_TAP;
                end
            endcase
        end
    endfunction

    // Delay seen at the pins for a given tap: tap plus the output stage
    function [TAP_W-1:0] tap_to_delay;
        input [TAP_W-1:0] tap;
        begin
            case (tap)
                5'h02: begin
                    tap_to_delay = 5'h03;
                end
                5'h03: begin
                    tap_to_delay = 5'h04;
                end
                5'h04: begin
                    tap_to_delay = 5'h05;
                end
                5'h05: begin
                    tap_to_delay = 5'h06;
                end
                5'h06: begin
                    tap_to_delay = 5'h07;
                end
                5'h07: begin
                    tap_to_delay = 5'h08;
                end
                5'h08: begin
                    tap_to_delay = 5'h09;
                end
                5'h09: begin
                    tap_to_delay = 5'h0A;
                end
                5'h0A: begin
                    tap_to_delay = 5'h0B;
                end
                5'h0B: begin
                    tap_to_delay = 5'h0C;
                end
                5'h0C: begin
                    tap_to_delay = 5'h0D;
                end
                5'h0D: begin
                    tap_to_delay = 5'h0E;
                end
                5'h0E: begin
                    tap_to_delay = 5'h0F;
                end
                5'h0F: begin
                    tap_to_delay = 5'h10;
                end
                5'h10: begin
                    tap_to_delay = 5'h11;
                end
                5'h11: begin
                    tap_to_delay = 5'h12;
                end
                default: begin
                    tap_to_delay = `VLSR_MIN_DELAY;
                end
            endcase
        end
    endfunction

    // Per-chain tap, shared by the data chains and the fill tracker
    function [TAP_W-1:0] chain_tap;
        input [CODE_W-1:0] code;
        input              fixed;
        begin
            if (fixed) begin
                chain_tap = `VLSR_LAST_TAP;
            end else begin
                chain_tap = code_to_tap(code);
            end
        end
    endfunction

    // Picks one bit of the fill tracker, stage numbering from one
    function tap_bit;
        input [DEPTH-1:0] line;
        input [TAP_W-1:0] tap;
        integer           k;
        begin
            tap_bit = 1'b0;
            for (k = 1; k <= DEPTH; k = k + 1) begin
                if (tap == k[TAP_W-1:0]) begin
                    tap_bit = line[k-1];
                end
            end
        end
    endfunction

    // Controls may change on any cycle; only selection depends on them
    always @(posedge clk_sys or posedge rst) begin // see RULE10 see RULE11
        if (rst) begin
            length_code <= `VLSR_CODE_RESET;
        end else begin
            length_code <= delay_length_code;
        end
    end

    always @(posedge clk_sys or posedge rst) begin // see RULE10
        if (rst) begin
            upper_fixed <= `VLSR_MODE_RESET;
        end else begin
            upper_fixed <= fixed_upper_mode;
        end
    end

    // Both selectors read the captured length code; only the upper selector reads the mode
    always @* begin // see RULE1 see RULE2 see RULE7
        lower_tap = chain_tap(length_code, 1'b0);
    end

    always @* begin // see RULE8 see RULE9
        upper_tap = chain_tap(length_code, upper_fixed);
    end

    // Lower nibble chain
    tap_chain #(
        .WIDTH    (WIDTH),
        .DEPTH    (DEPTH),
        .TAP_W    (TAP_W)
    ) lower_chain (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .data_in  (lower_nibble_in),
        .tap_sel  (lower_tap),
        .data_out (lower_nibble_out)
    ); // see RULE4

    // Upper nibble chain
    tap_chain #(
        .WIDTH    (WIDTH),
        .DEPTH    (DEPTH),
        .TAP_W    (TAP_W)
    ) upper_chain (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .data_in  (upper_nibble_in),
        .tap_sel  (upper_tap),
        .data_out (upper_nibble_out)
    ); // see RULE4

    // The data stages have no reset, so a parallel line of ones tells
    // the user when the output carries data accepted after reset
    always @(posedge clk_sys or posedge rst) begin // see RULE12
        if (rst) begin
            filled <= {DEPTH{1'b0}};
        end else begin
            filled <= {filled[DEPTH-2:0], 1'b1};
        end
    end

    always @* begin
        next_lower_valid = tap_bit(filled, lower_tap);
    end

    always @* begin
        next_upper_valid = tap_bit(filled, upper_tap);
    end

    // Valid flags and delay status line up with the output stage load
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lower_out_valid <= 1'b0;
        end else begin
            lower_out_valid <= next_lower_valid;
        end
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            upper_out_valid <= 1'b0;
        end else begin
            upper_out_valid <= next_upper_valid;
        end
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lower_delay <= `VLSR_MIN_DELAY;
        end else begin
            lower_delay <= tap_to_delay(lower_tap);
        end
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            upper_delay <= `VLSR_MIN_DELAY;
        end else begin
            upper_delay <= tap_to_delay(upper_tap);
        end
    end

endmodule // variable_length_shift_register

// ==== verif/vlsr_sva.sv ====
// Checker for the dual nibble variable length shift register.
// Assumes it sees only the top module's ports, attached by bind.
`timescale 1ns/1ns
module vlsr_sva #(
    parameter WIDTH  = 4,
    parameter CODE_W = 4,
    parameter TAP_W  = 5
) (
    input wire              clk_sys,
    input wire              rst,
    input wire [WIDTH-1:0]  lower_nibble_in,
    input wire [WIDTH-1:0]  upper_nibble_in,
    input wire [CODE_W-1:0] delay_length_code,
    input wire              fixed_upper_mode,
    input wire [WIDTH-1:0]  lower_nibble_out,
    input wire [WIDTH-1:0]  upper_nibble_out,
    input wire              lower_out_valid,
    input wire              upper_out_valid,
    input wire [TAP_W-1:0]  lower_delay,
    input wire [TAP_W-1:0]  upper_delay
);
    // History of inputs, index n is the value taken n edges ago
    reg [WIDTH-1:0] hl [1:18];
    reg [WIDTH-1:0] hu [1:18];
    integer k;
    always @(posedge clk_sys) begin
        hl[1] <= lower_nibble_in;
        hu[1] <= upper_nibble_in;
        for (k = 2; k < 19; k = k + 1) begin
            hl[k] <= hl[k-1];
            hu[k] <= hu[k-1];
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_lower_tap_data: assert property (lower_out_valid |->
        lower_nibble_out == hl[lower_delay]) else $error("lower data");
    a_upper_tap_data: assert property (upper_out_valid |->
        upper_nibble_out == hu[upper_delay]) else $error("upper data");
    a_code_sets_delay: assert property (lower_out_valid |->
        lower_delay == {1'b0, $past(delay_length_code, 2)} + 5'h03)
        else $error("lower delay");
    a_upper_fixed_len: assert property (upper_out_valid &&
        $past(fixed_upper_mode, 2) |-> upper_delay == 5'h12)
        else $error("fixed upper");
    a_upper_follows_code: assert property (upper_out_valid &&
        !$past(fixed_upper_mode, 2) |-> upper_delay == lower_delay)
        else $error("upper follow");
    a_lower_delay_range: assert property (lower_delay >= 5'h03 &&
        lower_delay <= 5'h12) else $error("lower range");
    a_upper_delay_range: assert property (upper_delay >= 5'h03 &&
        upper_delay <= 5'h12) else $error("upper range");
    // Valid at the longest tap means the whole line is filled, so both
    // chains stay valid whatever the code does next
    a_valid_stays_up: assert property (lower_out_valid &&
        lower_delay == 5'h12 |=> (lower_out_valid && upper_out_valid) [*2])
        else $error("valid drop");
    c_min_delay: cover property (lower_out_valid && lower_delay == 5'h03);
    c_max_delay: cover property (lower_out_valid && lower_delay == 5'h12);
    c_fixed_mode: cover property (upper_delay == 5'h12 && lower_delay < 5'h12);
endmodule // vlsr_sva
bind variable_length_shift_register vlsr_sva #(.WIDTH(WIDTH),
    .CODE_W(CODE_W), .TAP_W(TAP_W)) u_vlsr_sva (.clk_sys(clk_sys), .rst(rst),
    .lower_nibble_in(lower_nibble_in), .upper_nibble_in(upper_nibble_in),
    .delay_length_code(delay_length_code), .fixed_upper_mode(fixed_upper_mode),
    .lower_nibble_out(lower_nibble_out), .upper_nibble_out(upper_nibble_out),
    .lower_out_valid(lower_out_valid), .upper_out_valid(upper_out_valid),
    .lower_delay(lower_delay), .upper_delay(upper_delay));

// ==== verif/byte_feed.sv ====
// Upstream datapath model: a new byte on every rising edge.
// Assumes it shares clk_sys with the block.
`timescale 1ns/1ns
module byte_feed (
    input  wire       clk_sys,
    output reg  [7:0] data_byte
);
    // Odd step keeps bytes distinct across the longest delay
    initial data_byte = 8'h00;
    always @(posedge clk_sys) data_byte <= data_byte + 8'h35;
endmodule // byte_feed

// ==== verif/variable_length_shift_register_test.sv ====
// Testbench for the variable length shift register.
// Assumes the checker is bound and byte_feed supplies the data.
`timescale 1ns/1ns
module variable_length_shift_register_test;
    reg        clk_sys = 1'b0;
    reg        rst = 1'b1;
    reg  [3:0] code = 4'h0;
    reg        mode = 1'b0;
    reg  [3:0] cp1, cp2;
    reg        mp1, mp2;
    wire [7:0] byte_in;
    wire [3:0] lo_out, up_out;
    wire       lo_val, up_val;
    wire [4:0] lo_dly, up_dly;
    reg  [7:0] hist [1:18];
    reg  [14:0] rows [0:31];
    integer    mismatches = 0, checks = 0, cyc = 0, i, k;
    byte_feed u_byte_feed (.clk_sys(clk_sys), .data_byte(byte_in));
    variable_length_shift_register u_variable_length_shift_register (
        .clk_sys(clk_sys), .rst(rst), .lower_nibble_in(byte_in[3:0]),
        .upper_nibble_in(byte_in[7:4]), .delay_length_code(code),
        .fixed_upper_mode(mode), .lower_nibble_out(lo_out),
        .upper_nibble_out(up_out), .lower_out_valid(lo_val),
        .upper_out_valid(up_val), .lower_delay(lo_dly), .upper_delay(up_dly));
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    task check(input [7:0] seen, input [7:0] exp, input [63:0] what);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("FAIL %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task give_verdict;
        begin
            $display("checks %0d mismatches %0d", checks, mismatches);
            if (mismatches == 0 && checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            mismatches = mismatches + 1;
            give_verdict;
        end
        {cp1, cp2, mp1, mp2} <= {code, cp1, mode, mp1};
        hist[1] <= byte_in;
        for (k = 2; k < 19; k = k + 1) hist[k] <= hist[k-1];
    end
    initial begin
        // Row: mode, code, lower delay, upper delay
        for (i = 0; i < 32; i = i + 1)
            rows[i] = {i[4], i[3:0], i[3:0] + 5'h03,
                       i[4] ? 5'h12 : i[3:0] + 5'h03};
        repeat (19) @(posedge clk_sys);
        @(negedge clk_sys);
        check({lo_out, up_out}, 8'h00, "outs");
        check({lo_val, up_val}, 2'b00, "valids");
        check(lo_dly, 5'h03, "lo_dly");
        @(posedge clk_sys);
        rst <= 1'b0;
        for (i = 0; i < 32; i = i + 1) begin
            @(posedge clk_sys);
            code <= rows[i][13:10];
            mode <= rows[i][14];
            repeat (20) @(posedge clk_sys);
            @(negedge clk_sys);
            check(lo_dly, rows[i][9:5], "lo_dly");
            check(up_dly, rows[i][4:0], "up_dly");
            check(lo_out, hist[rows[i][9:5]][3:0], "lo_out");
            check(up_out, hist[rows[i][4:0]][7:4], "up_out");
            check(lo_val & up_val, 1'b1, "valid");
        end
        $display("table test done");
        // Code changes every cycle, mode every second cycle; stored stages must survive it
        for (i = 0; i < 12; i = i + 1) begin
            @(posedge clk_sys);
            code <= i[0] ? 4'hF : 4'h0;
            mode <= i[1];
            @(negedge clk_sys);
            check(lo_out, hist[{1'b0, cp2} + 5'h03][3:0], "lo_sw");
            check(up_out, hist[mp2 ? 5'h12 : {1'b0, cp2} + 5'h03][7:4],
                  "up_sw");
        end
        $display("switch test done");
        @(posedge clk_sys);
        code <= 4'h0;
        mode <= 1'b0;
        rst <= 1'b1;
        @(negedge clk_sys);
        check({lo_val, up_val, lo_out}, 6'h00, "rst_out");
        check(up_dly, 5'h03, "rst_dly");
        @(posedge clk_sys);
        rst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        check(lo_val, 1'b1, "lo_val");
        check(lo_out, hist[3][3:0], "lo_min");
        $display("reset test done");
        give_verdict;
    end
endmodule // variable_length_shift_register_test
